// ===== logic/nvb_flash_ops.sv
// nvb_flash_ops: page operation control of the embedded flash block.
// assumes avalon master on sys_clk; ecc flags and test port on the same clock.
`timescale 1ns/1ps
module nvb_flash_ops import nvb_pkg::*; #(
   parameter int unsigned PROG_CYCLES = PROG_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // operation status
   output logic busy,
   output logic [1:0] result_code,
   // array ecc checker flags
   input wire logic ecc_sbe,
   input wire logic ecc_dbe,
   // test port protection
   input wire logic tp_we,
   input wire logic [4:0] tp_page,
   input wire logic tp_rprot,
   input wire logic tp_wprot,
   input wire logic tp_key_ok,
   output logic tp_rd_ok,
   output logic tp_wr_ok
);
   // arrays
   logic [31:0] mem [NWORDS];
   logic [31:0] pb_mem [NBLK];
   logic [23:0] cnt_mem [NPG];
   logic lock_mem [NPG];
   logic rp_mem [NPG];
   logic wp_mem [NPG];

   // control state
   nvb_state_e st_q, st_d;
   nvb_req_s req_q, req_d;
   logic [19:0] cnt_q, cnt_d;
   logic [4:0] tgt_q, tgt_d;
   logic [1:0] res_q, res_d;
   logic [1:0] ecc_q, ecc_d;
   logic [31:0] rdat_q, rdat_d;
   logic bb_vld_q, bb_vld_d;
   nvb_loc_s bb_loc_q, bb_loc_d;
   logic [31:0] bb_dat_q, bb_dat_d;
   logic [1:0] bb_code_q, bb_code_d;
   logic [2:0] pf_cnt_q, pf_cnt_d;
   nvb_loc_s pf_loc_q, pf_loc_d;
   logic pb_vld_q, pb_vld_d;
   logic pb_mod_q, pb_mod_d;
   logic [4:0] pb_pg_q, pb_pg_d;
   logic [31:0] cfg_q, cfg_d;
   logic [31:0] addr_q, addr_d;
   logic [31:0] wdat_q, wdat_d;
   logic ack_q, ack_d;
   logic [31:0] rbk_q, rbk_d;
   logic tp_rd_q, tp_rd_d;
   logic tp_wr_q, tp_wr_d;

   // array write controls
   logic pg_wipe, pg_prog, cnt_inc, lock_wr, lock_val, pb_fill, pb_wr;
   logic [4:0] arr_pg;
   logic [3:0] pb_ix;
   logic [31:0] pb_wd;

   // working terms
   nvb_loc_s loc;
   nvb_req_s nreq;
   logic [4:0] pidx, ptgt;
   logic cmd, serve, in_pb, guard;
   logic [19:0] rd_cyc;
   logic [1:0] ecc_now;

   assign busy = (st_q != ST_IDLE);
   assign result_code = res_q;
   assign avs_readdata = rbk_q;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign tp_rd_ok = tp_rd_q;
   assign tp_wr_ok = tp_wr_q;

   always_comb begin
      st_d = st_q;
      req_d = req_q;
      cnt_d = cnt_q;
      tgt_d = tgt_q;
      res_d = res_q;
      ecc_d = ecc_q;
      rdat_d = rdat_q;
      bb_vld_d = bb_vld_q;
      bb_loc_d = bb_loc_q;
      bb_dat_d = bb_dat_q;
      bb_code_d = bb_code_q;
      pf_cnt_d = pf_cnt_q;
      pf_loc_d = pf_loc_q;
      pb_vld_d = pb_vld_q;
      pb_mod_d = pb_mod_q;
      pb_pg_d = pb_pg_q;
      cfg_d = cfg_q;
      addr_d = addr_q;
      wdat_d = wdat_q;
      rbk_d = rbk_q;
      pg_wipe = 1'b0;
      pg_prog = 1'b0;
      cnt_inc = 1'b0;
      lock_wr = 1'b0;
      lock_val = 1'b0;
      pb_fill = 1'b0;
      pb_wr = 1'b0;
      arr_pg = tgt_q;
      pb_ix = 4'h0;
      pb_wd = wdat_q;
      serve = 1'b0;
      nreq = req_q;
      ptgt = pb_pg_q;
      guard = cfg_q[C_GUARD];
      rd_cyc = RD_CYC + 20'(cfg_q[C_PIPE]);
      ecc_now = ecc_code({ecc_dbe, ecc_sbe});
      loc = nvb_loc_s'(addr_q[8:0]);
      pidx = pg_idx(loc);
      in_pb = pb_vld_q && (pb_pg_q == pidx);

      // bus slave: one wait cycle, then the access completes
      ack_d = (avs_read || avs_write) && !ack_q;
      cmd = avs_write && ack_q && (avs_address == REG_CTRL);
      if (avs_read && !ack_q) begin
         unique case (avs_address)
            REG_CTRL: rbk_d = cfg_q & CFG_MASK;
            REG_ADDR: rbk_d = addr_q;
            REG_WDATA: rbk_d = wdat_q;
            REG_RDATA: rbk_d = rdat_q;
            REG_STAT: rbk_d = {27'h0, pb_mod_q, pb_vld_q, res_q, busy};
            default: rbk_d = 32'h0;
         endcase
      end
      if (avs_write && ack_q) begin
         unique case (avs_address)
            REG_CTRL: cfg_d = be_merge(cfg_q, avs_writedata, avs_byteenable) & CFG_MASK;
            REG_ADDR: addr_d = be_merge(addr_q, avs_writedata, avs_byteenable);
            REG_WDATA: wdat_d = be_merge(wdat_q, avs_writedata, avs_byteenable);
            default: ;
         endcase
      end

      // read-ahead engine runs whenever a prefetch is pending
      if (pf_cnt_q != 3'h0) begin
         pf_cnt_d = pf_cnt_q - 3'h1;
         if (pf_cnt_q == 3'h1) begin
            bb_vld_d = 1'b1;
            bb_loc_d = pf_loc_q;
            bb_dat_d = mem[word_idx(pf_loc_q)];
            bb_code_d = ecc_now;
         end
      end

      unique case (st_q)
         ST_IDLE: begin
            if (cmd) begin
               nreq.op = avs_writedata[C_READ] ? OP_READ :
                         avs_writedata[C_WRITE] ? OP_WRITE :
                         avs_writedata[C_WIPE] ? OP_WIPE :
                         avs_writedata[C_PROG] ? OP_PROG :
                         avs_writedata[C_CLEAR] ? OP_CLEAR :
                         avs_writedata[C_DROP] ? OP_DROP : OP_NONE;
               nreq.loc = loc;
               nreq.info = avs_writedata[C_INFO];
               nreq.ahead = avs_writedata[C_AHEAD];
               nreq.lock = avs_writedata[C_LOCK];
               guard = avs_writedata[C_GUARD];
               // the alternate destination only matters for program and wipe
               nreq.alt = (nreq.op == OP_WIPE || nreq.op == OP_PROG) &&
                          avs_writedata[C_ALT];
               rd_cyc = RD_CYC + 20'(avs_writedata[C_PIPE]);
               req_d = nreq;
               ecc_d = 2'h0;
               if (nreq.op != OP_NONE) res_d = RES_OK;
               unique case (nreq.op)
                  OP_READ: begin
                     if (nreq.info) begin
                        rdat_d = {cnt_mem[pidx], 4'h0, cnt_mem[pidx] > WRITE_LIMIT,
                                  rp_mem[pidx], wp_mem[pidx], lock_mem[pidx]};
                     end else if (in_pb) begin
                        rdat_d = pb_mem[loc.aux ? AUX_BLK : 4'(loc.blk)];
                     end else if (bb_vld_q && bb_loc_q == loc) begin
                        rdat_d = bb_dat_q;
                        res_d = bb_code_q;
                        if (nreq.ahead) begin
                           pf_cnt_d = PF_CYC;
                           pf_loc_d = next_loc(loc);
                        end
                     end else begin
                        st_d = ST_FETCH;
                        cnt_d = (pf_cnt_q != 3'h0) ? 20'h0 : rd_cyc;
                     end
                  end
                  OP_WRITE: begin
                     if (lock_mem[pidx]) begin
                        res_d = RES_01;
                     end else if (!in_pb) begin
                        if (guard && pb_mod_q) begin
                           res_d = RES_11;
                        end else begin
                           st_d = ST_COPY;
                           cnt_d = COPY_CYC;
                        end
                     end else begin
                        pb_wr = 1'b1;
                        pb_ix = loc.aux ? AUX_BLK : 4'(loc.blk);
                        pb_mod_d = 1'b1;
                     end
                  end
                  OP_WIPE: begin
                     tgt_d = pidx;
                     if (lock_mem[pidx]) begin
                        res_d = RES_01;
                     end else if (guard && pb_vld_q && pb_pg_q != pidx) begin
                        res_d = RES_01;
                     end else if (!nreq.alt && pb_vld_q && pb_mod_q && pb_pg_q != pidx) begin
                        res_d = RES_01;
                     end else begin
                        st_d = ST_NVM;
                        cnt_d = 20'(PROG_CYCLES);
                     end
                  end
                  OP_PROG: begin
                     ptgt = nreq.alt ? pidx : pb_pg_q;
                     tgt_d = ptgt;
                     if (!pb_vld_q || (!nreq.alt && pidx != pb_pg_q)) begin
                        res_d = RES_01;
                     end else if (lock_mem[ptgt] || (guard && ptgt != pb_pg_q)) begin
                        res_d = RES_01;
                     end else begin
                        st_d = ST_NVM;
                        cnt_d = 20'(PROG_CYCLES);
                     end
                  end
                  OP_CLEAR: begin
                     if (in_pb) begin
                        lock_wr = 1'b1;
                        arr_pg = pidx;
                     end else if (guard && pb_mod_q) begin
                        res_d = RES_11;
                     end else begin
                        st_d = ST_COPY;
                        cnt_d = COPY_CYC;
                     end
                  end
                  OP_DROP: st_d = ST_DISC;
                  default: ;
               endcase
            end
         end
         ST_FETCH: begin
            if (pf_cnt_q != 3'h0) begin
               // a look-ahead in flight must finish before the array is free
               if (pf_cnt_q == 3'h1) begin
                  if (pf_loc_q == req_q.loc) serve = 1'b1;
                  else cnt_d = rd_cyc;
               end
            end else if (cnt_q <= 20'h1) begin
               serve = 1'b1;
            end else begin
               cnt_d = cnt_q - 20'h1;
            end
         end
         ST_COPY: begin
            ecc_d = ecc_q | {ecc_dbe, ecc_sbe};
            cnt_d = cnt_q - 20'h1;
            if (cnt_q == 20'h1) begin
               pb_fill = 1'b1;
               arr_pg = pg_idx(req_q.loc);
               pb_vld_d = 1'b1;
               pb_pg_d = pg_idx(req_q.loc);
               pb_mod_d = 1'b0;
               res_d = ecc_code(ecc_d);
               st_d = ST_IDLE;
               if (req_q.op == OP_CLEAR) begin
                  lock_wr = 1'b1;
               end else if (!ecc_d[1]) begin
                  pb_wr = 1'b1;
                  pb_ix = req_q.loc.aux ? AUX_BLK : 4'(req_q.loc.blk);
                  pb_mod_d = 1'b1;
               end
            end
         end
         ST_NVM: begin
            ecc_d = ecc_q | {ecc_dbe, 1'b0};
            cnt_d = cnt_q - 20'h1;
            if (cnt_q <= 20'h1) begin
               cnt_inc = 1'b1;
               st_d = ST_IDLE;
               if (ecc_d[1]) res_d = RES_10;
               else if (cnt_mem[tgt_q] >= WRITE_LIMIT) res_d = RES_11;
               if (req_q.op == OP_WIPE) begin
                  pg_wipe = 1'b1;
                  if (bb_vld_q && pg_idx(bb_loc_q) == tgt_q) bb_vld_d = 1'b0;
               end else begin
                  pg_prog = 1'b1;
                  lock_wr = 1'b1;
                  lock_val = req_q.lock;
                  pb_mod_d = 1'b0;
                  pb_pg_d = tgt_q;
               end
            end
         end
         ST_DISC: begin
            pb_mod_d = 1'b0;
            st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase

      if (serve) begin
         rdat_d = mem[word_idx(req_q.loc)];
         res_d = ecc_now;
         bb_vld_d = 1'b1;
         bb_loc_d = req_q.loc;
         bb_dat_d = mem[word_idx(req_q.loc)];
         bb_code_d = ecc_now;
         st_d = ST_IDLE;
         if (req_q.ahead) begin
            pf_cnt_d = PF_CYC;
            pf_loc_d = next_loc(req_q.loc);
         end
      end

      // protect bits only gate test-port access, and the key overrides them
      tp_rd_d = !rp_mem[tp_page] || tp_key_ok;
      tp_wr_d = !wp_mem[tp_page] || tp_key_ok;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_IDLE;
         req_q <= '0;
         cnt_q <= 20'h0;
         tgt_q <= 5'h0;
         res_q <= RES_OK;
         ecc_q <= 2'h0;
         rdat_q <= 32'h0;
         bb_vld_q <= 1'b0;
         bb_loc_q <= '0;
         bb_dat_q <= 32'h0;
         bb_code_q <= RES_OK;
         pf_cnt_q <= 3'h0;
         pf_loc_q <= '0;
         pb_vld_q <= 1'b0;
         pb_mod_q <= 1'b0;
         pb_pg_q <= 5'h0;
         cfg_q <= CFG_RESET;
         addr_q <= 32'h0;
         wdat_q <= 32'h0;
         ack_q <= 1'b0;
         rbk_q <= 32'h0;
         tp_rd_q <= 1'b0;
         tp_wr_q <= 1'b0;
      end else begin
         st_q <= st_d;
         req_q <= req_d;
         cnt_q <= cnt_d;
         tgt_q <= tgt_d;
         res_q <= res_d;
         ecc_q <= ecc_d;
         rdat_q <= rdat_d;
         bb_vld_q <= bb_vld_d;
         bb_loc_q <= bb_loc_d;
         bb_dat_q <= bb_dat_d;
         bb_code_q <= bb_code_d;
         pf_cnt_q <= pf_cnt_d;
         pf_loc_q <= pf_loc_d;
         pb_vld_q <= pb_vld_d;
         pb_mod_q <= pb_mod_d;
         pb_pg_q <= pb_pg_d;
         cfg_q <= cfg_d;
         addr_q <= addr_d;
         wdat_q <= wdat_d;
         ack_q <= ack_d;
         rbk_q <= rbk_d;
         tp_rd_q <= tp_rd_d;
         tp_wr_q <= tp_wr_d;
      end
   end

   // per-page flags start clear, as on a freshly erased array
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NPG; i++) begin
            cnt_mem[i] <= 24'h0;
            lock_mem[i] <= 1'b0;
            rp_mem[i] <= 1'b0;
            wp_mem[i] <= 1'b0;
         end
      end else begin
         if (cnt_inc) cnt_mem[arr_pg] <= cnt_mem[arr_pg] + 24'h1;
         if (lock_wr) lock_mem[arr_pg] <= lock_val;
         if (tp_we) begin
            rp_mem[tp_page] <= tp_rprot;
            wp_mem[tp_page] <= tp_wprot;
         end
      end
   end

   // data arrays hold no reset: contents are the nonvolatile image
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < NBLK; i++) begin
         if (pg_wipe) mem[8'(arr_pg) * NBLK_B + 8'(i)] <= 32'h0;
         if (pg_prog) mem[8'(arr_pg) * NBLK_B + 8'(i)] <= pb_mem[i];
         if (pb_fill) pb_mem[i] <= mem[8'(arr_pg) * NBLK_B + 8'(i)];
      end
      if (pb_wr) pb_mem[pb_ix] <= pb_wd;
   end
endmodule

// ===== logic/nvb_pkg.sv
// nvb_pkg: constants, types and helpers for the flash page-operation block.
// assumes one 125 MHz clock; software drives the block over an Avalon-MM slave.
package nvb_pkg;
   // geometry: 4 sectors of 4 pages plus one spare page, 9 one-word blocks
   localparam int NSEC = 4;
   localparam int PPS = 4;
   localparam int NPG = NSEC * (PPS + 1);
   localparam int NBLK = 9;
   localparam int NWORDS = NPG * NBLK;
   localparam logic [4:0] PG_STRIDE = 5'h05;
   localparam logic [4:0] SPARE_PG = 5'h04;
   localparam logic [3:0] AUX_BLK = 4'h8;
   localparam logic [2:0] LAST_BLK = 3'h7;
   localparam logic [7:0] NBLK_B = 8'h09;
   localparam logic [23:0] WRITE_LIMIT = 24'h0003e8;
   // register byte offsets
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_ADDR = 5'h04;
   localparam logic [4:0] REG_WDATA = 5'h08;
   localparam logic [4:0] REG_RDATA = 5'h0c;
   localparam logic [4:0] REG_STAT = 5'h10;
   // control word: op strobes in [5:0], level options above
   localparam int C_READ = 0;
   localparam int C_WRITE = 1;
   localparam int C_WIPE = 2;
   localparam int C_PROG = 3;
   localparam int C_CLEAR = 4;
   localparam int C_DROP = 5;
   localparam int C_INFO = 8;
   localparam int C_AHEAD = 9;
   localparam int C_ALT = 10;
   localparam int C_LOCK = 11;
   localparam int C_GUARD = 12;
   localparam int C_PIPE = 13;
   localparam logic [31:0] CFG_MASK = 32'h00003f00;
   localparam logic [31:0] CFG_RESET = 32'h00000000;
   // result codes
   localparam logic [1:0] RES_OK = 2'h0;
   localparam logic [1:0] RES_01 = 2'h1;
   localparam logic [1:0] RES_10 = 2'h2;
   localparam logic [1:0] RES_11 = 2'h3;
   // timing
   localparam int CLK_NS = 8;
   localparam int PROG_TIME_NS = 6800000;
   localparam int PROG_CYC = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [19:0] RD_CYC = 20'h00005;
   localparam logic [19:0] COPY_CYC = 20'h00037;
   localparam logic [2:0] PF_CYC = 3'h5;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001, ST_FETCH = 5'b00010, ST_COPY = 5'b00100,
      ST_NVM = 5'b01000, ST_DISC = 5'b10000
   } nvb_state_e;
   typedef enum logic [2:0] {
      OP_NONE, OP_READ, OP_WRITE, OP_WIPE, OP_PROG, OP_CLEAR, OP_DROP
   } nvb_op_e;
   typedef struct packed {
      logic [1:0] sec;
      logic [1:0] pg;
      logic spare;
      logic aux;
      logic [2:0] blk;
   } nvb_loc_s;
   typedef struct packed {
      nvb_op_e op;
      nvb_loc_s loc;
      logic info;
      logic ahead;
      logic alt;
      logic lock;
   } nvb_req_s;

   function automatic logic [4:0] pg_idx(input nvb_loc_s l);
      return 5'(l.sec) * PG_STRIDE + (l.spare ? SPARE_PG : 5'(l.pg));
   endfunction
   function automatic logic [7:0] word_idx(input nvb_loc_s l);
      return 8'(pg_idx(l)) * NBLK_B + (l.aux ? 8'(AUX_BLK) : 8'(l.blk));
   endfunction
   function automatic nvb_loc_s next_loc(input nvb_loc_s l);
      nvb_loc_s n;
      n = l;
      if (l.spare && !l.aux) begin
         n.sec = l.sec + 2'h1;
         n.blk = 3'h0;
      end else if (l.aux || l.blk == LAST_BLK) begin
         if (!l.aux) n.blk = 3'h0;
         n.pg = l.pg + 2'h1;
         if (l.pg == 2'h3) n.sec = l.sec + 2'h1;
      end else begin
         n.blk = l.blk + 3'h1;
      end
      return n;
   endfunction
   function automatic logic [1:0] ecc_code(input logic [1:0] dbe_sbe);
      return dbe_sbe[1] ? RES_10 : (dbe_sbe[0] ? RES_01 : RES_OK);
   endfunction
   function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[i*8 +: 8] = n[i*8 +: 8];
      end
      return r;
   endfunction
endpackage

// ===== verif/nvb_far_model.sv
// nvb_far_model: array error flags and test port facing the block.
// assumes the bench commands error injection and protect writes.
`timescale 1ns/1ps
module nvb_far_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // bench commands
   input wire logic [1:0] ecc_mode,
   input wire logic tp_go,
   input wire logic [4:0] tp_pg,
   input wire logic key,
   // block side
   output logic ecc_sbe,
   output logic ecc_dbe,
   output logic tp_we,
   output logic [4:0] tp_page,
   output logic tp_rprot,
   output logic tp_wprot,
   output logic tp_key_ok
);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         {ecc_sbe, ecc_dbe, tp_we, tp_rprot, tp_wprot, tp_key_ok} <= 6'h00;
         tp_page <= 5'h00;
      end else begin
         ecc_sbe <= ecc_mode[0];
         ecc_dbe <= ecc_mode[1];
         tp_we <= tp_go;
         // outside a write the values wander so nothing relies on stale ones
         tp_page <= tp_go ? tp_pg : tp_page + 5'h01;
         tp_rprot <= tp_go ? 1'b1 : ~tp_rprot;
         tp_wprot <= tp_go ? 1'b0 : ~tp_wprot;
         tp_key_ok <= key;
      end
   end
endmodule

// ===== verif/nvb_flash_ops_test.sv
// nvb_flash_ops_test: self-checking bench for the page operation block.
// assumes nvb_far_model beside the block and the port checker bound in.
`timescale 1ns/1ps
module nvb_flash_ops_test import nvb_pkg::*; ;
   localparam logic [31:0] RD = 32'h1 << C_READ, WRT = 32'h1 << C_WRITE;
   localparam logic [31:0] WIPE = 32'h1 << C_WIPE, PROG = 32'h1 << C_PROG;
   localparam logic [31:0] CLR = 32'h1 << C_CLEAR, DROP = 32'h1 << C_DROP;
   localparam logic [31:0] INFO = RD | (32'h1 << C_INFO), AHD = 32'h1 << C_AHEAD;
   localparam logic [31:0] ALT = 32'h1 << C_ALT, LOCK = 32'h1 << C_LOCK;
   localparam logic [31:0] GRD = 32'h1 << C_GUARD, PIPE = 32'h1 << C_PIPE;
   logic sys_clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, tgo = 1'b0, key = 1'b0;
   logic [4:0] adr = 5'h00, tpg = 5'h00, tpage;
   logic [3:0] be = 4'hf;
   logic [31:0] wd = 32'h0, rdat, got;
   logic wait_r, busy, sbe, dbe, twe, trp, twp, tko, tro, twk;
   logic [1:0] ecc = 2'h0;
   int errors = 0, n_tests = 0, cyc = 0, bc;
   int cnt[20] = '{default: 0};
   logic [3:0] fl[20] = '{default: 4'h0};

   nvb_flash_ops #(.PROG_CYCLES(20)) nvb_flash_ops_i (
      .sys_clk(sys_clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wait_r), .busy(busy), .result_code(), .ecc_sbe(sbe), .ecc_dbe(dbe),
      .tp_we(twe), .tp_page(tpage), .tp_rprot(trp), .tp_wprot(twp), .tp_key_ok(tko),
      .tp_rd_ok(tro), .tp_wr_ok(twk));
   nvb_far_model nvb_far_model_i (
      .sys_clk(sys_clk), .rst(rst), .ecc_mode(ecc), .tp_go(tgo), .tp_pg(tpg), .key(key),
      .ecc_sbe(sbe), .ecc_dbe(dbe), .tp_we(twe), .tp_page(tpage), .tp_rprot(trp),
      .tp_wprot(twp), .tp_key_ok(tko));

   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] inf(input int i);
      return {24'(cnt[i]), 4'h0, fl[i]};
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, s, e);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      @(posedge sys_clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      be <= b;
      do @(posedge sys_clk); while (wait_r !== 1'b0);
      got = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // operation, wait out busy, then fetch the read data word
   task automatic op(input logic [31:0] c, input logic [8:0] a);
      bus(1'b1, REG_ADDR, {23'h0, a}, 4'hf);
      bus(1'b1, REG_CTRL, c, 4'hf);
      bc = 0;
      @(posedge sys_clk);
      while (busy === 1'b1 && bc < 200) begin
         bc++;
         @(posedge sys_clk);
      end
      bus(1'b0, REG_RDATA, 32'h0, 4'hf);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         print_verdict();
      end
   end

   initial begin
      int s, g, p, q;
      logic [8:0] pa, qa;
      logic [31:0] d;
      void'($urandom(5));
      s = $urandom % 4;
      g = $urandom % 4;
      pa = 9'(s * 128 + g * 32 + $urandom % 8);
      qa = 9'(((s + 1) % 4) * 128 + g * 32);
      p = s * 5 + g;
      q = ((s + 1) % 4) * 5 + g;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      bus(1'b0, REG_STAT, 32'h0, 4'hf);
      chk(got, 32'h0);
      bus(1'b0, REG_CTRL, 32'h0, 4'hf);
      chk(got, CFG_RESET);
      bus(1'b0, 5'h14, 32'h0, 4'hf);
      chk(got, 32'h0);
      $display("test reset done");
      op(WIPE, pa);
      cnt[p]++;
      chk(nvb_flash_ops_i.result_code, RES_OK);
      op(INFO, pa);
      chk(got, inf(p));
      op(RD, pa);
      chk(got, 32'h0);
      $display("test wipe done");
      d = $urandom;
      bus(1'b1, REG_WDATA, d, 4'hf);
      bus(1'b1, REG_WDATA, 32'h5a, 4'h1);
      d[7:0] = 8'h5a;
      op(WRT, pa);
      chk(nvb_flash_ops_i.result_code, RES_OK);
      op(PROG | LOCK, pa);
      cnt[p]++;
      fl[p] = 4'h1;
      op(INFO, pa);
      chk(got, inf(p));
      op(RD, pa);
      chk(got, d);
      op(WIPE, pa);
      chk(nvb_flash_ops_i.result_code, RES_01);
      tpg <= 5'(p);
      tgo <= 1'b1;
      key <= 1'b1;
      @(posedge sys_clk);
      tgo <= 1'b0;
      fl[p] = 4'h5;
      op(INFO, pa);
      chk(got, inf(p));
      chk(tro, 1'b1);
      chk(twk, 1'b1);
      key <= 1'b0;
      op(CLR, pa);
      fl[p] = 4'h4;
      chk(nvb_flash_ops_i.result_code, RES_OK);
      op(INFO, pa);
      chk(got, inf(p));
      $display("test lock done");
      op(WRT | GRD, pa);
      op(WRT | GRD, qa);
      chk(nvb_flash_ops_i.result_code, RES_11);
      op(WIPE | GRD, qa);
      chk(nvb_flash_ops_i.result_code, RES_01);
      op(CLR | GRD, qa);
      chk(nvb_flash_ops_i.result_code, RES_11);
      op(DROP | GRD, qa);
      chk(32'(bc), 32'h1);
      op(WIPE, qa);
      cnt[q]++;
      chk(nvb_flash_ops_i.result_code, RES_OK);
      $display("test guard done");
      ecc <= 2'h1;
      op(RD, qa);
      chk(nvb_flash_ops_i.result_code, RES_01);
      ecc <= 2'h2;
      op(RD, qa + 9'h1);
      chk(nvb_flash_ops_i.result_code, RES_10);
      ecc <= 2'h0;
      op(RD | PIPE, qa + 9'h2);
      chk(32'(bc), 32'h6);
      op(RD | AHD, qa + 9'h3);
      op(RD | AHD, qa + 9'h4);
      chk(32'(bc), 32'h0);
      op(RD | AHD, qa);
      chk(32'(bc <= 9), 32'h1);
      chk(got, 32'h0);
      op(RD | ALT, qa + 9'h5);
      chk({got[29:0], nvb_flash_ops_i.result_code}, 32'h0);
      $display("test read done");
      ecc <= 2'h2;
      op(WIPE, qa);
      chk(nvb_flash_ops_i.result_code, RES_10);
      ecc <= 2'h0;
      $display("test wipe error done");
      print_verdict();
   end
endmodule

// ===== verif/nvb_ops_props.sv
// checker: bus handshake, busy and result timing of nvb_flash_ops.
// assumes a master that holds each request until waitrequest is low.
`timescale 1ns/1ps
module nvb_ops_props import nvb_pkg::*; #(
   parameter int unsigned PROG_CYCLES = PROG_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // bus
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // status
   input wire logic busy,
   input wire logic [1:0] result_code,
   input wire logic tp_key_ok,
   input wire logic tp_rd_ok,
   input wire logic tp_wr_ok
);
   // copy plus write-back is the longest run apart from program and wipe
   localparam int unsigned BMAX = PROG_CYCLES > 64 ? PROG_CYCLES : 64;
   logic [19:0] run_q;
   logic ack;
   assign ack = avs_write && !avs_waitrequest && avs_address == REG_CTRL;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         run_q <= 20'h0;
      end else begin
         run_q <= busy ? run_q + 20'h1 : 20'h0;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   chk_wait_first: assert property (
      (avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
      else $error("access answered without a wait cycle");
   chk_wait_once: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("access held off too long");
   chk_busy_cause: assert property (
      $rose(busy) |-> $past(ack)) else $error("busy rose without an operation");
   chk_result_hold: assert property (
      $changed(result_code) |-> $past(busy) || $past(ack))
      else $error("result changed while idle");
   chk_busy_bound: assert property (
      busy |-> run_q <= 20'(BMAX)) else $error("busy ran too long");
   chk_drop_pulse: assert property (
      ack && !busy && avs_writedata[5:0] == 6'h20 |=> busy ##1 !busy)
      else $error("drop busy not one cycle");
   chk_unmapped_zero: assert property (
      avs_read && !avs_waitrequest && avs_address > REG_STAT |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   chk_key_open: assert property (
      tp_key_ok |=> tp_rd_ok && tp_wr_ok) else $error("key did not open test port");
   cov_drop: cover property (ack && avs_writedata[5:0] == 6'h20);
   cov_code11: cover property (result_code == RES_11);
   cov_copy: cover property (run_q == 20'd55);
endmodule

bind nvb_flash_ops nvb_ops_props #(.PROG_CYCLES(PROG_CYCLES)) nvb_ops_props_i (
   .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .busy(busy), .result_code(result_code),
   .tp_key_ok(tp_key_ok), .tp_rd_ok(tp_rd_ok), .tp_wr_ok(tp_wr_ok)
);
